// ===== include/hbw_pkg.sv
// Package for the parallel host write port: widths, reset values, timing.
// Assumes a single system clock; the host bus pins are sampled by it.
package hbw_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 16;
    localparam int REG_WORDS = 256;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] REG_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] DOUT_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    localparam logic [2:0]        STRB_IDLE  = 3'h7;
    localparam logic [ADDR_W+DATA_W-1:0] BUS_RESET = 24'h000000;

    // ------------------------------------------------------------------
    // Strobe vector field positions (cs, wr, rd; all active low)
    // ------------------------------------------------------------------
    localparam int STRB_CS = 0;
    localparam int STRB_WR = 1;
    localparam int STRB_RD = 2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WR_NS       = 50;
    localparam int T_WRDT_NS     = 40;
    // Least times round up, never below one cycle
    localparam int WR_MIN_CYC =
        ((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int WRDT_MIN_CYC =
        ((T_WRDT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((T_WRDT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Bus cycle states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        HBW_IDLE  = 3'b001,
        HBW_WRITE = 3'b010,
        HBW_READ  = 3'b100
    } hbw_state_t;

endpackage

// ===== hdl/hbw_sync.sv
// Two-stage synchroniser for a vector of host bus pins.
// Assumes the first stage feeds only the second stage.
module hbw_sync
    import hbw_pkg::*;
#(
    parameter int                W         = 1,
    parameter logic [W-1:0]      RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RESET_VAL;
            q_reg    <= RESET_VAL;
        end else if (clk_en) begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;

endmodule

// ===== hdl/hbw_host_port.sv
// Parallel host bus port: host writes and reads the 16-bit register file.
// Assumes host pins are plain inputs; the data bus is split in/out/enable.
//
// Summary of operation
// - A valid write stores the data word into the addressed register.
// - A write starts once select and write are both low, in any order.
// - A write ends as soon as select or write returns high.
// - Every register is reachable for read and write over this port.
// - With select and read low and write high the register is driven.
// - A read ends and the bus is released when select or read rises.
module hbw_host_port
    import hbw_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    // Host bus pins
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic              host_cs_n,
    input  wire logic              host_wr_n,
    input  wire logic              host_rd_n,
    input  wire logic [DATA_W-1:0] host_data_in,
    output logic      [DATA_W-1:0] host_data_out,
    output logic                   host_data_oe_n,
    // Core update of status registers
    input  wire logic              core_ld_en,
    input  wire logic [ADDR_W-1:0] core_ld_addr,
    input  wire logic [DATA_W-1:0] core_ld_data,
    // Write notification to the core
    output logic                   core_wr_pulse,
    output logic      [ADDR_W-1:0] core_wr_addr,
    output logic      [DATA_W-1:0] core_wr_data,
    // Status
    output logic                   host_clash
);

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [2:0]               strb_s;
    logic [ADDR_W+DATA_W-1:0] bus_s;

    // Address and data pass the same number of stages as the strobes,
    // so a zero hold time still lines up with the strobe edge seen here.
    // A strobe low for less than one clock may be missed entirely;
    // the host must respect that at this clock rate.
    hbw_sync #(
        .W         (3),
        .RESET_VAL (STRB_IDLE)
    ) u_strb_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .d       ({host_rd_n, host_wr_n, host_cs_n}),
        .q       (strb_s)
    );

    hbw_sync #(
        .W         (ADDR_W + DATA_W),
        .RESET_VAL (BUS_RESET)
    ) u_bus_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .d       ({host_addr, host_data_in}),
        .q       (bus_s)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire              cs_s   = strb_s[STRB_CS];
    wire              wr_s   = strb_s[STRB_WR];
    wire              rd_s   = strb_s[STRB_RD];
    wire [ADDR_W-1:0] addr_s = bus_s[ADDR_W+DATA_W-1:DATA_W];
    wire [DATA_W-1:0] data_s = bus_s[DATA_W-1:0];

    // Overlap of both lows, whichever fell last
    wire wr_active = !cs_s && !wr_s;
    // Read only with write high; a clash never drives the bus
    wire rd_active = !cs_s && !rd_s && wr_s;
    wire clash     = !cs_s && !wr_s && !rd_s;

    // ------------------------------------------------------------------
    // Cycle state machine
    // ------------------------------------------------------------------
    hbw_state_t state_reg;
    hbw_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HBW_IDLE: begin
                if (wr_active) begin
                    state_next = HBW_WRITE;
                end else if (rd_active) begin
                    state_next = HBW_READ;
                end
            end
            HBW_WRITE: begin
                // Either strobe rising closes the write
                if (!wr_active) begin
                    state_next = rd_active ? HBW_READ : HBW_IDLE;
                end
            end
            HBW_READ: begin
                if (wr_active) begin
                    state_next = HBW_WRITE;
                end else if (!rd_active) begin
                    state_next = HBW_IDLE;
                end
            end
            default: begin
                state_next = HBW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= HBW_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // Current and next state decode
    wire in_write = (state_reg == HBW_WRITE);
    wire to_write = (state_next == HBW_WRITE);

    // One commit on entry to the write state, never again in that cycle
    wire commit  = to_write && !in_write;
    wire reading = (state_next == HBW_READ);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] regs [REG_WORDS];

    // Host write wins over a core load to the same word, so software
    // sees its own value when both hit that word in the same cycle.
    wire same_word  = (core_ld_addr == addr_s);
    wire core_ld_ok = core_ld_en && !(commit && same_word);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < REG_WORDS; i++) begin
                regs[i] <= REG_RESET;
            end
        end else if (clk_en) begin
            if (commit) begin
                regs[addr_s] <= data_s;
            end
            if (core_ld_ok) begin
                regs[core_ld_addr] <= core_ld_data;
            end
        end
    end

    wire [DATA_W-1:0] rd_word = regs[addr_s];

    // ------------------------------------------------------------------
    // Read data drive
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] dout_reg;
    logic              oe_n_reg;

    // Bus shows zero when not reading, never stale register data
    wire [DATA_W-1:0] dout_next = reading ? rd_word : DOUT_RESET;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dout_reg <= DOUT_RESET;
            oe_n_reg <= 1'b1;
        end else if (clk_en) begin
            dout_reg <= dout_next;
            oe_n_reg <= !reading;
        end
    end

    // ------------------------------------------------------------------
    // Core notification and status
    // ------------------------------------------------------------------
    logic              wr_pulse_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [DATA_W-1:0] wr_data_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_pulse_reg <= 1'b0;
            wr_addr_reg  <= ADDR_RESET;
            wr_data_reg  <= REG_RESET;
        end else if (clk_en) begin
            wr_pulse_reg <= commit;
            if (commit) begin
                wr_addr_reg <= addr_s;
                wr_data_reg <= data_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // Protocol status
    // ------------------------------------------------------------------
    // Level, not sticky: software only sees it while the clash lasts
    logic clash_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clash_reg <= 1'b0;
        end else if (clk_en) begin
            // Host broke the strobe protocol; flag only
            clash_reg <= clash;
        end
    end

    assign host_data_out  = dout_reg;
    assign host_data_oe_n = oe_n_reg;
    assign core_wr_pulse  = wr_pulse_reg;
    assign core_wr_addr   = wr_addr_reg;
    assign core_wr_data   = wr_data_reg;
    assign host_clash     = clash_reg;

endmodule

// ===== test/hbw_host_port_props.sv
// Checker for the host port: cycle timing seen at the pins.
// Assumes clk_en is held high by the bench.
module hbw_host_port_props
    import hbw_pkg::*;
(
    // Clock, reset, enable
    input wire logic              clk_sys,
    input wire logic              resetn,
    input wire logic              clk_en,
    // Host bus pins
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic              host_cs_n,
    input wire logic              host_wr_n,
    input wire logic              host_rd_n,
    input wire logic [DATA_W-1:0] host_data_in,
    input wire logic [DATA_W-1:0] host_data_out,
    input wire logic              host_data_oe_n,
    // Core load
    input wire logic              core_ld_en,
    input wire logic [ADDR_W-1:0] core_ld_addr,
    input wire logic [DATA_W-1:0] core_ld_data,
    // Core notification and status
    input wire logic              core_wr_pulse,
    input wire logic [ADDR_W-1:0] core_wr_addr,
    input wire logic [DATA_W-1:0] core_wr_data,
    input wire logic              host_clash
);
    wire logic wr_ov = !host_cs_n && !host_wr_n;
    wire logic rd_ov = !host_cs_n && !host_rd_n && host_wr_n;
    wire logic all_low = wr_ov && !host_rd_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_write_commits: assert property (
        $rose(wr_ov) |-> ##[2:4] core_wr_pulse) else $error("no commit");
    a_single_commit: assert property (
        core_wr_pulse |=> !core_wr_pulse) else $error("double commit");
    a_commit_cause: assert property (
        core_wr_pulse |-> $past(wr_ov, 3)) else $error("commit w/o cycle");
    a_commit_word: assert property (
        core_wr_pulse |-> core_wr_addr == $past(host_addr, 3)
        && core_wr_data == $past(host_data_in, 3)) else $error("bad word");
    a_read_drive: assert property (
        rd_ov[*5] |-> !host_data_oe_n) else $error("read not driven");
    a_read_release: assert property (
        (!rd_ov)[*5] |-> host_data_oe_n) else $error("bus not released");
    a_write_no_drive: assert property (
        (!host_wr_n)[*5] |-> host_data_oe_n) else $error("driven in write");
    a_clash_flag: assert property (
        all_low[*5] |-> host_clash) else $error("clash not flagged");
endmodule
bind hbw_host_port hbw_host_port_props hbw_host_port_props_i (.*);

// ===== test/hbw_host_model.sv
// Host processor model driving the parallel bus pins.
// Assumes the port samples its pins on clk_sys.
module hbw_host_model
    import hbw_pkg::*;
(
    // Clock
    input  wire logic              clk_sys,
    // Bus pins
    output logic      [ADDR_W-1:0] host_addr,
    output logic                   host_cs_n,
    output logic                   host_wr_n,
    output logic                   host_rd_n,
    output logic      [DATA_W-1:0] host_data_in,
    input  wire logic [DATA_W-1:0] host_data_out,
    input  wire logic              host_data_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {host_addr, host_data_in} = BUS_RESET;
        {host_rd_n, host_wr_n, host_cs_n} = STRB_IDLE;
    end
    // Later strobe starts the cycle; clash only when asked
    task automatic write_word(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input bit cs_first, input bit clash);
        @(posedge clk_sys);
        host_addr <= a;
        host_data_in <= d;
        host_rd_n <= !clash;
        if (cs_first) host_cs_n <= 1'b0;
        else host_wr_n <= 1'b0;
        @(posedge clk_sys);
        host_cs_n <= 1'b0;
        host_wr_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        {host_rd_n, host_wr_n, host_cs_n} <= STRB_IDLE;
        // Released lines must not keep the last value
        host_data_in <= ~d;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic read_word(input logic [ADDR_W-1:0] a,
        output logic [DATA_W-1:0] d, output logic oe_n);
        @(posedge clk_sys);
        host_addr <= a;
        host_cs_n <= 1'b0;
        host_rd_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        d = host_data_out;
        oe_n = host_data_oe_n;
        {host_rd_n, host_wr_n, host_cs_n} <= STRB_IDLE;
        repeat (5) @(posedge clk_sys);
    endtask
endmodule

// ===== test/tb_top.sv
// Bench for the host port: corner and random writes, full read-back.
// Assumes the host model owns every bus pin.
module tb_top
    import hbw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] host_addr;
    logic host_cs_n, host_wr_n, host_rd_n, host_data_oe_n;
    logic core_wr_pulse, host_clash;
    logic [DATA_W-1:0] host_data_in, host_data_out;
    logic [DATA_W-1:0] shadow [REG_WORDS];
    int fail_count = 0;
    int n_checks = 0;
    int n_pulse = 0;
    int n_wr = 0;
    int cyc = 0;
    int n_clash = 0;
    logic clash_q = 1'b0;
    logic core_ld_en = 1'b0;
    logic [ADDR_W-1:0] core_ld_addr = ADDR_RESET;
    logic [DATA_W-1:0] core_ld_data = REG_RESET;
    always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    hbw_host_model hbw_host_model_i (.clk_sys(clk_sys),
        .host_addr(host_addr), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
        .host_rd_n(host_rd_n), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n));
    hbw_host_port hbw_host_port_i (.clk_sys(clk_sys), .resetn(resetn),
        .clk_en(1'b1), .host_addr(host_addr), .host_cs_n(host_cs_n),
        .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe_n(host_data_oe_n), .core_ld_en(core_ld_en),
        .core_ld_addr(core_ld_addr), .core_ld_data(core_ld_data),
        .core_wr_pulse(core_wr_pulse), .core_wr_addr(), .core_wr_data(),
        .host_clash(host_clash));
    function automatic logic [DATA_W-1:0] exp_word(logic [ADDR_W-1:0] a);
        return shadow[a];
    endfunction
    task automatic chk16(input logic [DATA_W-1:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
        bit csf, bit clash);
        hbw_host_model_i.write_word(a, d, csf, clash);
        shadow[a] = d;
        n_wr++;
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (resetn && core_wr_pulse === 1'b1) n_pulse++;
        if (resetn && host_clash === 1'b1 && !clash_q) n_clash++;
        clash_q <= (host_clash === 1'b1);
        cyc++;
        // Whole run needs about 3300 cycles
        if (cyc == 10000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        logic [DATA_W-1:0] d;
        logic oe;
        logic [DATA_W-1:0] ld;
        void'($urandom(26));
        foreach (shadow[i]) shadow[i] = REG_RESET;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk1(host_data_oe_n, 1'b1);
        chk16(host_data_out, DOUT_RESET);
        wr(8'h00, 16'hFFFF, 1'b1, 1'b0);
        wr(8'hFF, 16'h0001, 1'b0, 1'b0);
        wr(8'hFF, 16'hA5A5, 1'b1, 1'b0);
        wr(8'h10, 16'h1234, 1'b0, 1'b1);
        for (int i = 0; i < 40; i++) begin
            wr(8'($urandom), 16'($urandom), 1'($urandom), 1'b0);
        end
        // Core load of one word, seen by the host read-back below
        ld = 16'($urandom);
        @(posedge clk_sys);
        core_ld_en   <= 1'b1;
        core_ld_addr <= 8'h20;
        core_ld_data <= ld;
        @(posedge clk_sys);
        core_ld_en   <= 1'b0;
        shadow[8'h20] = ld;
        for (int i = 0; i < REG_WORDS; i++) begin
            hbw_host_model_i.read_word(8'(i), d, oe);
            chk1(oe, 1'b0);
            chk16(d, exp_word(8'(i)));
        end
        chk16(16'(n_pulse), 16'(n_wr));
        chk16(16'(n_clash), 16'h0001);
        report_and_stop();
    end
endmodule
